// ### hw/accel_offset_sleep_selftest.sv
`include "accel_cfg.svh"
`default_nettype none
// What this block does
// [R1] Samples keep flowing with a ready pulse in reduced-power mode too.
// [R2] With sleep, auto sleep and link on, inactivity puts the part asleep.
// [R3] Activity while asleep restores the programmed rate and flags activity.
// [R4] Waking on activity disarms activity detection and rearms inactivity detection.
// [R5] Each axis adds its signed 8-bit trim to every sample it stores.
// [R6] One trim step weighs 15.6 mg, scaled to the active output resolution.
// [R7] In wide-scale mode one trim step moves the output by four steps.
// [R8] The trim registers read zero after power-up.
// [R9] Rate bits 3 to 0 choose the output data rate.
// [R10] Rate bit 4 selects reduced-power sampling; the host clears it first.
// [R11] Format bit 3 selects wide scale and range bits 1 to 0 pick the range.
// [R12] Format bit 7 applies the self-test stimulus while it is set.
// [R13] The host drops about four samples after self-test is switched on.
// [R14] Reading the cause clears the flags; a pending activity blocks sleep.
// [R15] The motion status register shows whether the part is asleep.
// [R16] A new trim applies from the next sample on, never mid-sample.
module accel_offset_sleep_selftest #(
    parameter int SAMPLE_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic raw_valid,
    input wire logic [SAMPLE_W-1:0] raw_x,
    input wire logic [SAMPLE_W-1:0] raw_y,
    input wire logic [SAMPLE_W-1:0] raw_z,
    input wire logic sleep_en,
    input wire logic auto_sleep_en,
    input wire logic link_en,
    input wire logic act_detect,
    input wire logic inact_detect,
    input wire logic int_cause_rd,
    output logic [SAMPLE_W-1:0] x_result,
    output logic [SAMPLE_W-1:0] y_result,
    output logic [SAMPLE_W-1:0] z_result,
    output logic data_ready,
    output logic act_int,
    output logic inact_int,
    output logic act_det_en,
    output logic inact_det_en,
    output logic asleep,
    output logic [3:0] odr_active,
    output logic low_power,
    output logic wide_scale_sel,
    output logic [1:0] range_sel,
    output logic self_test_on
);

    typedef struct packed {
        accel_pkg::sleep_state_t state;
        logic [7:0] x_trim;
        logic [7:0] y_trim;
        logic [7:0] z_trim;
        logic [7:0] rate;
        logic [7:0] fmt;
        logic [SAMPLE_W-1:0] x_res;
        logic [SAMPLE_W-1:0] y_res;
        logic [SAMPLE_W-1:0] z_res;
        logic [7:0] rdata;
        logic drdy;
        logic act_int;
        logic inact_int;
        logic act_en;
        logic inact_en;
        logic [3:0] odr;
    } state_t;

    localparam state_t RST_ST = '{
        state: accel_pkg::AWAKE,
        x_trim: `TRIM_RESET,
        y_trim: `TRIM_RESET,
        z_trim: `TRIM_RESET,
        rate: `RATE_RESET,
        fmt: `FORMAT_RESET,
        odr: `ODR_RESET,
        inact_en: 1'b1,
        default: '0
    };

    state_t st_ff;
    state_t nxt_st;
    logic sleep_ok;

    function automatic logic [SAMPLE_W-1:0] scale_trim(
        input logic [7:0] t,
        input logic wide,
        input logic [1:0] rng
    );
        logic signed [SAMPLE_W-1:0] e;
        e = SAMPLE_W'($signed(t));
        if (wide || rng == 2'h0) begin
            scale_trim = e <<< 2;
        end else if (rng == 2'h1) begin
            scale_trim = e <<< 1;
        end else if (rng == 2'h2) begin
            scale_trim = e;
        end else begin
            scale_trim = e >>> 1;
        end
    endfunction

    always_comb begin
        nxt_st = st_ff;
        sleep_ok = sleep_en && auto_sleep_en && link_en;
        if (reg_wr_en) begin
            case (reg_addr)
                `X_TRIM_ADDR: nxt_st.x_trim = reg_wdata;
                `Y_TRIM_ADDR: nxt_st.y_trim = reg_wdata;
                `Z_TRIM_ADDR: nxt_st.z_trim = reg_wdata;
                `RATE_CTRL_ADDR: nxt_st.rate = reg_wdata;
                `FORMAT_CTRL_ADDR: nxt_st.fmt = reg_wdata;
                default: ;
            endcase
        end
        // [R1] Samples always pass.
        nxt_st.drdy = raw_valid;
        if (raw_valid) begin
            // [R5] Trim added per axis.
            // [R6] Trim step scaling.
            // [R7] Wide scale quadruples.
            // [R16] Trim sampled before write.
            nxt_st.x_res = raw_x + scale_trim(st_ff.x_trim,
                st_ff.fmt[`WIDE_SCALE_BIT], st_ff.fmt[1:0]);
            nxt_st.y_res = raw_y + scale_trim(st_ff.y_trim,
                st_ff.fmt[`WIDE_SCALE_BIT], st_ff.fmt[1:0]);
            nxt_st.z_res = raw_z + scale_trim(st_ff.z_trim,
                st_ff.fmt[`WIDE_SCALE_BIT], st_ff.fmt[1:0]);
        end
        // [R14] Cause read clears flags.
        if (int_cause_rd) begin
            nxt_st.act_int = 1'b0;
            nxt_st.inact_int = 1'b0;
        end
        if (!link_en) begin
            nxt_st.act_en = 1'b1;
            nxt_st.inact_en = 1'b1;
        end
        unique case (st_ff.state)
            accel_pkg::AWAKE: begin
                // [R2] Inactivity enters sleep.
                // [R14] Pending activity blocks.
                if (sleep_ok && inact_detect && st_ff.inact_en &&
                    !st_ff.act_int) begin
                    nxt_st.state = accel_pkg::ASLEEP;
                    nxt_st.inact_int = 1'b1;
                    nxt_st.inact_en = 1'b0;
                    nxt_st.act_en = 1'b1;
                end
            end
            accel_pkg::ASLEEP: begin
                // [R3] Activity wakes up.
                // [R4] Detection alternates back.
                if (act_detect && st_ff.act_en) begin
                    nxt_st.state = accel_pkg::AWAKE;
                    nxt_st.act_int = 1'b1;
                    nxt_st.act_en = 1'b0;
                    nxt_st.inact_en = 1'b1;
                end else if (!sleep_ok) begin
                    nxt_st.state = accel_pkg::AWAKE;
                end
            end
        endcase
        // [R9] Programmed rate when awake.
        if (nxt_st.state == accel_pkg::ASLEEP) begin
            nxt_st.odr = `SLEEP_ODR;
        end else begin
            nxt_st.odr = nxt_st.rate[3:0];
        end
        if (reg_rd_en) begin
            case (reg_addr)
                `X_TRIM_ADDR: nxt_st.rdata = st_ff.x_trim;
                `Y_TRIM_ADDR: nxt_st.rdata = st_ff.y_trim;
                `Z_TRIM_ADDR: nxt_st.rdata = st_ff.z_trim;
                // [R15] Asleep status bit.
                `MOTION_STATUS_ADDR: nxt_st.rdata =
                    8'(st_ff.state == accel_pkg::ASLEEP) << `ASLEEP_BIT;
                `RATE_CTRL_ADDR: nxt_st.rdata = st_ff.rate;
                `FORMAT_CTRL_ADDR: nxt_st.rdata = st_ff.fmt;
                `X_RES_LO_ADDR: nxt_st.rdata = st_ff.x_res[7:0];
                `X_RES_HI_ADDR: nxt_st.rdata = st_ff.x_res[15:8];
                `Y_RES_LO_ADDR: nxt_st.rdata = st_ff.y_res[7:0];
                `Y_RES_HI_ADDR: nxt_st.rdata = st_ff.y_res[15:8];
                `Z_RES_LO_ADDR: nxt_st.rdata = st_ff.z_res[7:0];
                `Z_RES_HI_ADDR: nxt_st.rdata = st_ff.z_res[15:8];
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    // [R8] Trims clear at reset.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_ff <= RST_ST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign x_result = st_ff.x_res;
    assign y_result = st_ff.y_res;
    assign z_result = st_ff.z_res;
    assign data_ready = st_ff.drdy;
    assign act_int = st_ff.act_int;
    assign inact_int = st_ff.inact_int;
    assign act_det_en = st_ff.act_en;
    assign inact_det_en = st_ff.inact_en;
    assign asleep = st_ff.state[1];
    assign odr_active = st_ff.odr;
    // [R10] Reduced-power select.
    assign low_power = st_ff.rate[`LOW_POWER_BIT];
    // [R11] Resolution and range.
    assign wide_scale_sel = st_ff.fmt[`WIDE_SCALE_BIT];
    assign range_sel = st_ff.fmt[1:0];
    // [R12] Self-test stimulus.
    assign self_test_on = st_ff.fmt[`SELF_TEST_BIT];

    chk_trim_reset_zero: assert property ( // [R8]
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(rst_b) |-> (x_result == '0) && (reg_rdata == 8'h00) &&
            (st_ff.x_trim == 8'h00) && (st_ff.y_trim == 8'h00) &&
            (st_ff.z_trim == 8'h00))
        else $error("trim not zero after reset");

    chk_wide_trim_sum: assert property ( // [R7]
        @(posedge sys_clk) disable iff (!rst_b)
        (raw_valid && wide_scale_sel) |=> x_result ==
            SAMPLE_W'($past(raw_x) +
            (SAMPLE_W'($signed($past(st_ff.x_trim))) <<< 2)))
        else $error("wide scale trim sum wrong");

    chk_fixed_trim_sum: assert property ( // [R6]
        @(posedge sys_clk) disable iff (!rst_b)
        (raw_valid && !wide_scale_sel && range_sel == 2'h2) |=>
            z_result == SAMPLE_W'($past(raw_z) +
            SAMPLE_W'($signed($past(st_ff.z_trim)))))
        else $error("fixed mode trim sum wrong");

    chk_sample_ready: assert property ( // [R1]
        @(posedge sys_clk) disable iff (!rst_b)
        raw_valid |=> data_ready ##1 (data_ready == $past(raw_valid)))
        else $error("sample ready pulse missing");

    chk_sleep_entry: assert property ( // [R2]
        @(posedge sys_clk) disable iff (!rst_b)
        (!asleep && sleep_en && auto_sleep_en && link_en && inact_detect &&
            inact_det_en && !act_int) |=>
            asleep && !inact_det_en && act_det_en &&
            odr_active == `SLEEP_ODR)
        else $error("sleep entry wrong");

    chk_wake_rate: assert property ( // [R3]
        @(posedge sys_clk) disable iff (!rst_b)
        (asleep && act_detect && act_det_en) |=>
            !asleep && act_int && odr_active == $past(st_ff.rate[3:0]))
        else $error("wake did not restore rate");

    chk_wake_rearm: assert property ( // [R4]
        @(posedge sys_clk) disable iff (!rst_b)
        (asleep && act_detect && act_det_en && link_en) |=>
            !act_det_en && inact_det_en)
        else $error("detection did not alternate");

    chk_act_blocks: assert property ( // [R14]
        @(posedge sys_clk) disable iff (!rst_b)
        (!asleep && act_int) |=> !asleep)
        else $error("slept with activity pending");

    chk_asleep_status: assert property ( // [R15]
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_rd_en && reg_addr == `MOTION_STATUS_ADDR) |=>
            reg_rdata[`ASLEEP_BIT] == $past(asleep))
        else $error("asleep status wrong");

    chk_odr_follow: assert property ( // [R9]
        @(posedge sys_clk) disable iff (!rst_b)
        !asleep |-> odr_active == st_ff.rate[3:0])
        else $error("awake rate differs from control");

endmodule
`default_nettype wire

// ### common/accel_cfg.svh
`ifndef ACCEL_CFG_SVH
`define ACCEL_CFG_SVH

`define X_TRIM_ADDR 6'h1E
`define Y_TRIM_ADDR 6'h1F
`define Z_TRIM_ADDR 6'h20
`define MOTION_STATUS_ADDR 6'h2B
`define RATE_CTRL_ADDR 6'h2C
`define FORMAT_CTRL_ADDR 6'h31
`define X_RES_LO_ADDR 6'h32
`define X_RES_HI_ADDR 6'h33
`define Y_RES_LO_ADDR 6'h34
`define Y_RES_HI_ADDR 6'h35
`define Z_RES_LO_ADDR 6'h36
`define Z_RES_HI_ADDR 6'h37

`define TRIM_RESET 8'h00
`define ODR_RESET 4'hA
`define RATE_RESET {4'h0, `ODR_RESET}
`define FORMAT_RESET 8'h00
`define SLEEP_ODR 4'h8

`define LOW_POWER_BIT 4
`define WIDE_SCALE_BIT 3
`define SELF_TEST_BIT 7
`define ASLEEP_BIT 3
`define RANGE_16G 2'h3

`endif

// ### common/accel_pkg.sv
`default_nettype none
package accel_pkg;
    typedef enum logic [1:0] {
        AWAKE = 2'b01,
        ASLEEP = 2'b10
    } sleep_state_t;
endpackage
`default_nettype wire

// ### testbench/host_model.sv
`include "accel_cfg.svh"
`default_nettype none
module host_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic int_cause_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        int_cause_rd = 1'b0;
    end
    // Idle bus lines show the inverse of the last value.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
    task automatic start_self_test();
        wr(`RATE_CTRL_ADDR, 8'h0D);
        wr(`FORMAT_CTRL_ADDR, 8'h8B);
    endtask
    task automatic stop_self_test();
        wr(`FORMAT_CTRL_ADDR, 8'h0B);
    endtask
    task automatic clear_cause();
        @(negedge sys_clk);
        int_cause_rd = 1'b1;
        @(negedge sys_clk);
        int_cause_rd = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### testbench/accel_offset_sleep_selftest_test.sv
`include "accel_cfg.svh"
`default_nettype none
module accel_offset_sleep_selftest_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic raw_valid = 1'b0;
    logic [15:0] raw_x = 16'h0000, raw_y = 16'h0000, raw_z = 16'h0000;
    logic sleep_en = 1'b0, auto_sleep_en = 1'b0, link_en = 1'b0;
    logic act_detect = 1'b0, inact_detect = 1'b0;
    logic reg_wr_en, reg_rd_en, int_cause_rd;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    logic [15:0] x_result, y_result, z_result;
    logic data_ready, act_int, inact_int, act_det_en, inact_det_en, asleep;
    logic low_power, wide_scale_sel, self_test_on;
    logic [3:0] odr_active;
    logic [1:0] range_sel;
    logic [7:0] codes [5] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0F};
    int failures = 0;
    int compares = 0;
    accel_offset_sleep_selftest dut_u (.sys_clk, .rst_b, .reg_wr_en,
        .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .raw_valid, .raw_x,
        .raw_y, .raw_z, .sleep_en, .auto_sleep_en, .link_en, .act_detect,
        .inact_detect, .int_cause_rd, .x_result, .y_result, .z_result,
        .data_ready, .act_int, .inact_int, .act_det_en, .inact_det_en,
        .asleep, .odr_active, .low_power, .wide_scale_sel, .range_sel,
        .self_test_on);
    host_model host_u (.sys_clk, .reg_rdata, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wdata, .int_cause_rd);
    always #25 sys_clk = ~sys_clk;
    task automatic chk_reg(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_smp(input string n, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, g);
        chk_reg(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic rchk(input string n, input logic [5:0] a, logic [7:0] e);
        host_u.rd(a, rd_val);
        chk_reg(n, e, rd_val);
    endtask
    task automatic smp(input logic [15:0] x, y, z, ex, ey, ez);
        @(negedge sys_clk);
        raw_valid = 1'b1;
        raw_x = x;
        raw_y = y;
        raw_z = z;
        @(negedge sys_clk);
        raw_valid = 1'b0;
        chk_bit("data_ready", 1'b1, data_ready);
        chk_smp("x_result", ex, x_result);
        chk_smp("y_result", ey, y_result);
        chk_smp("z_result", ez, z_result);
    endtask
    task automatic settle(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            raw_valid = 1'b1;
            @(negedge sys_clk);
            raw_valid = 1'b0;
        end
    endtask
    task automatic det(input logic act);
        @(negedge sys_clk);
        act_detect = act;
        inact_detect = !act;
        @(negedge sys_clk);
        act_detect = 1'b0;
        inact_detect = 1'b0;
    endtask
    task automatic chk_sleep(input logic [4:0] e);
        chk_reg("sleep_flags", {3'h0, e}, {3'h0, asleep, act_int, inact_int,
            act_det_en, inact_det_en});
    endtask
    function automatic logic [15:0] scl(input logic signed [7:0] t, int f);
        logic signed [15:0] w;
        w = 16'(t);
        return (f == 3) ? w >>> 1 : w <<< (2 - f);
    endfunction
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        rst_b = 1'b1;
        rchk("x_axis_trim", `X_TRIM_ADDR, `TRIM_RESET);
        rchk("y_axis_trim", `Y_TRIM_ADDR, `TRIM_RESET);
        rchk("z_axis_trim", `Z_TRIM_ADDR, `TRIM_RESET);
        rchk("unmapped", 6'h00, 8'h00);
        rchk("sample_rate_control", `RATE_CTRL_ADDR, 8'h0A);
        rchk("output_format_control", `FORMAT_CTRL_ADDR, 8'h00);
        host_u.wr(`FORMAT_CTRL_ADDR, 8'h0B);
        host_u.wr(`X_TRIM_ADDR, 8'hFD);
        host_u.wr(`Y_TRIM_ADDR, 8'h03);
        host_u.wr(`Z_TRIM_ADDR, 8'hFE);
        rchk("x_axis_trim", `X_TRIM_ADDR, 8'hFD);
        chk_bit("wide_scale_sel", 1'b1, wide_scale_sel);
        chk_reg("range_sel", 8'h03, {6'h00, range_sel});
        smp(16'h000A, 16'hFFF3, 16'h0009,
            16'hFFFE, 16'hFFFF, 16'h0001);
        rchk("x_result_lo", `X_RES_LO_ADDR, 8'hFE);
        rchk("x_result_hi", `X_RES_HI_ADDR, 8'hFF);
        rchk("y_result_hi", `Y_RES_HI_ADDR, 8'hFF);
        rchk("z_result_lo", `Z_RES_LO_ADDR, 8'h01);
        for (int f = 0; f < 4; f++) begin
            host_u.wr(`FORMAT_CTRL_ADDR, 8'(f));
            smp(16'h0064, 16'h0064, 16'h0064, 16'h0064 + scl(8'hFD, f),
                16'h0064 + scl(8'h03, f), 16'h0064 + scl(8'hFE, f));
        end
        host_u.wr(`FORMAT_CTRL_ADDR, 8'h0B);
        fork
            host_u.wr(`X_TRIM_ADDR, 8'h01);
            smp(16'h0064, 16'h0064, 16'h0064,
                16'h0058, 16'h0070, 16'h005C);
        join
        smp(16'h0064, 16'h0064, 16'h0064,
            16'h0068, 16'h0070, 16'h005C);
        host_u.wr(`RATE_CTRL_ADDR, 8'h1C);
        chk_bit("low_power", 1'b1, low_power);
        smp(16'h0064, 16'h0064, 16'h0064,
            16'h0068, 16'h0070, 16'h005C);
        foreach (codes[i]) begin
            host_u.wr(`RATE_CTRL_ADDR, codes[i]);
            chk_reg("odr_active", codes[i], {4'h0, odr_active});
        end
        host_u.start_self_test();
        chk_bit("self_test_on", 1'b1, self_test_on);
        chk_bit("low_power", 1'b0, low_power);
        settle(4);
        smp(16'h0064, 16'h0064, 16'h0064,
            16'h0068, 16'h0070, 16'h005C);
        host_u.stop_self_test();
        chk_bit("self_test_on", 1'b0, self_test_on);
        sleep_en = 1'b1;
        auto_sleep_en = 1'b1;
        link_en = 1'b1;
        det(1'b0);
        chk_sleep(5'b10110);
        chk_reg("odr_active", {4'h0, `SLEEP_ODR}, {4'h0, odr_active});
        rchk("motion_status", `MOTION_STATUS_ADDR, 8'h08);
        det(1'b1);
        chk_sleep(5'b01101);
        chk_reg("odr_active", 8'h0D, {4'h0, odr_active});
        det(1'b0);
        chk_sleep(5'b01101);
        host_u.clear_cause();
        chk_sleep(5'b00001);
        det(1'b0);
        chk_sleep(5'b10110);
        link_en = 1'b0;
        @(negedge sys_clk);
        chk_sleep(5'b00111);
        wrap_up();
    end
endmodule
`default_nettype wire
